// File: hdl/acsd_top.sv
// acsd_top.sv: aux pll control, reference select and output divider
// assumes: oscillator and vco edges arrive as one-cycle ticks on core_clk,
// lock comes from the analog pll as a synchronous level
`timescale 1ns/10ps
`include "acsd_cfg.svh"
module acsd_top import acsd_pkg::*; (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // register port
    input  wire logic [`ACSD_ADDR_W-1:0] reg_addr,
    input  wire logic [`ACSD_DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output      logic [`ACSD_DATA_W-1:0] reg_rdata,
    // source ticks and pll status
    input  wire logic                    rc_osc_tick,
    input  wire logic                    primary_osc_tick,
    input  wire logic                    alt_ref_tick,
    input  wire logic                    pll_vco_tick,
    input  wire logic                    pll_lock_in,
    // pll control
    output      logic                    pll_enable,
    output      acsd_ref_e               pll_ref_sel,
    output      logic                    pll_ref_tick,
    // divided clock and interrupt
    output      logic                    aux_clk_tick,
    output      logic                    irq
);

    // -----------------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------------
    acsd_ctrl_s                  ctrl_ff;        // software control bits
    acsd_ctrl_s                  nxt_ctrl;
    acsd_pll_e                   pll_st_ff;      // lock tracking
    acsd_pll_e                   nxt_pll_st;
    logic [`ACSD_EV_W-1:0]       stat_ff;        // sticky events
    logic [`ACSD_EV_W-1:0]       nxt_stat;
    logic [`ACSD_EV_W-1:0]       mask_ff;        // interrupt mask
    logic [`ACSD_EV_W-1:0]       nxt_mask;
    logic [`ACSD_EV_W-1:0]       events;         // this cycle's events
    logic [`ACSD_DATA_W-1:0]     rdata_ff;       // read answer
    logic [`ACSD_DATA_W-1:0]     nxt_rdata;
    logic                        irq_ff;
    logic                        nxt_irq;
    acsd_ref_e                   ref_sel_ff;     // pll reference code
    acsd_ref_e                   nxt_ref_sel;
    logic                        ref_tick_ff;    // chosen reference tick
    logic                        nxt_ref_tick;
    logic                        div_src_tick;   // divider input tick
    logic                        lock_flag;      // lock as software sees it
    logic                        wr_ctrl;
    logic                        wr_stat;
    logic                        wr_mask;
    acsd_ctrl_s                  ctrl_view;      // control as read back

    assign wr_ctrl   = reg_wr && (reg_addr == `ACSD_CTRL_OFS);
    assign wr_stat   = reg_wr && (reg_addr == `ACSD_STAT_OFS);
    assign wr_mask   = reg_wr && (reg_addr == `ACSD_MASK_OFS);
    assign lock_flag = (pll_st_ff == ACSD_PLL_LOCKED);

    // -----------------------------------------------------------------------
    // control register: only writable fields stored, lock bit never
    // -----------------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            // writes to lock and reserved bits are dropped here
            nxt_ctrl = acsd_ctrl_s'(reg_wdata & `ACSD_CTRL_WMASK);
        end
    end

    // -----------------------------------------------------------------------
    // lock tracking; lock input ignored while pll is held off
    // -----------------------------------------------------------------------
    always_comb begin
        nxt_pll_st = pll_st_ff;
        events     = '0;
        case (pll_st_ff)
            ACSD_PLL_OFF: begin
                if (ctrl_ff.aux_pll_enable) begin
                    nxt_pll_st = ACSD_PLL_WAIT;
                end
            end
            ACSD_PLL_WAIT: begin
                if (!ctrl_ff.aux_pll_enable) begin
                    nxt_pll_st = ACSD_PLL_OFF;
                end else if (pll_lock_in) begin
                    nxt_pll_st                 = ACSD_PLL_LOCKED;
                    events[`ACSD_EV_LOCK_GAIN] = 1'b1;
                end
            end
            ACSD_PLL_LOCKED: begin
                // turning the pll off on purpose is not reported as a loss
                if (!ctrl_ff.aux_pll_enable) begin
                    nxt_pll_st = ACSD_PLL_OFF;
                end else if (!pll_lock_in) begin
                    nxt_pll_st                 = ACSD_PLL_WAIT;
                    events[`ACSD_EV_LOCK_LOSS] = 1'b1;
                end
            end
            default: begin
                nxt_pll_st = ACSD_PLL_OFF;
            end
        endcase
    end

    // -----------------------------------------------------------------------
    // status, mask, interrupt; a new event beats a same-cycle clear
    // -----------------------------------------------------------------------
    always_comb begin
        nxt_stat = stat_ff;
        if (wr_stat) begin
            nxt_stat = stat_ff & ~reg_wdata[`ACSD_EV_W-1:0];
        end
        nxt_stat = nxt_stat | events;
        nxt_mask = wr_mask ? reg_wdata[`ACSD_EV_W-1:0] : mask_ff;
        nxt_irq  = |(nxt_stat & nxt_mask);
    end

    // -----------------------------------------------------------------------
    // reference routing to the pll
    // -----------------------------------------------------------------------
    always_comb begin
        if (ctrl_ff.internal_rc_reference_select) begin
            nxt_ref_sel  = ACSD_REF_RC;
            nxt_ref_tick = rc_osc_tick;
        end else if (ctrl_ff.aux_reference_select) begin
            nxt_ref_sel  = ACSD_REF_PRI;
            nxt_ref_tick = primary_osc_tick;
        end else begin
            nxt_ref_sel  = ACSD_REF_ALT;
            nxt_ref_tick = alt_ref_tick;
        end
        // a held-off pll gets no reference edges
        if (!ctrl_ff.aux_pll_enable) begin
            nxt_ref_tick = 1'b0;
        end
    end

    // divider runs from the vco only when chosen, else the primary osc
    assign div_src_tick = ctrl_ff.aux_divider_source_select ? pll_vco_tick
                                                            : primary_osc_tick;

    // -----------------------------------------------------------------------
    // read mux; unmapped addresses answer zero
    // -----------------------------------------------------------------------
    always_comb begin
        ctrl_view                   = ctrl_ff;
        ctrl_view.aux_pll_lock_flag = lock_flag;
        nxt_rdata                   = '0;
        if (reg_rd) begin
            case (reg_addr)
                `ACSD_CTRL_OFS: nxt_rdata = ctrl_view;
                `ACSD_STAT_OFS: nxt_rdata = {{(`ACSD_DATA_W-`ACSD_EV_W){1'b0}}, stat_ff};
                `ACSD_MASK_OFS: nxt_rdata = {{(`ACSD_DATA_W-`ACSD_EV_W){1'b0}}, mask_ff};
                default:        nxt_rdata = '0;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_ff     <= acsd_ctrl_s'(`ACSD_CTRL_RESET);
            pll_st_ff   <= ACSD_PLL_OFF;
            stat_ff     <= `ACSD_EV_RESET;
            mask_ff     <= `ACSD_EV_RESET;
            irq_ff      <= 1'b0;
            rdata_ff    <= '0;
            ref_sel_ff  <= ACSD_REF_ALT;
            ref_tick_ff <= 1'b0;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            pll_st_ff   <= nxt_pll_st;
            stat_ff     <= nxt_stat;
            mask_ff     <= nxt_mask;
            irq_ff      <= nxt_irq;
            rdata_ff    <= nxt_rdata;
            ref_sel_ff  <= nxt_ref_sel;
            ref_tick_ff <= nxt_ref_tick;
        end
    end

    // -----------------------------------------------------------------------
    // output divider
    // -----------------------------------------------------------------------
    acsd_clk_div #(
        .CNT_W      (`ACSD_DIV_CNT_W)
    ) u_div (
        .core_clk   (core_clk),
        .rst        (rst),
        .src_tick   (div_src_tick),
        .ratio_code (ctrl_ff.aux_output_divide_ratio),
        .div_tick   (aux_clk_tick)
    );

    assign reg_rdata    = rdata_ff;
    assign pll_enable   = ctrl_ff.aux_pll_enable;
    assign pll_ref_sel  = ref_sel_ff;
    assign pll_ref_tick = ref_tick_ff;
    assign irq          = irq_ff;

    // -----------------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_pll_en_write: assert property (wr_ctrl |=> pll_enable == $past(reg_wdata[15]))
        else $error("pll enable does not follow control write");
    a_pll_en_hold: assert property (!wr_ctrl |=> $stable(pll_enable))
        else $error("pll enable moved without a control write");
    a_div_bypass: assert property (
        (ctrl_ff.aux_output_divide_ratio == `ACSD_RATIO_BYPASS) && !wr_ctrl
        && div_src_tick |=> aux_clk_tick)
        else $error("divide by one missed a source tick");
    a_div_by_two: assert property (
        (ctrl_ff.aux_output_divide_ratio == 3'h6) && aux_clk_tick
        |-> !$past(aux_clk_tick) || $past(ctrl_ff.aux_output_divide_ratio) != 3'h6)
        else $error("divide by two ticked on consecutive cycles");
    a_ref_rc_pick: assert property (
        ctrl_ff.internal_rc_reference_select |=> pll_ref_sel == ACSD_REF_RC)
        else $error("rc select did not route rc oscillator");
    a_ref_pri_alt: assert property (
        !ctrl_ff.internal_rc_reference_select
        |=> pll_ref_sel == ($past(ctrl_ff.aux_reference_select) ? ACSD_REF_PRI
                                                                : ACSD_REF_ALT))
        else $error("reference select routed the wrong source");
    a_lock_read: assert property (
        reg_rd && (reg_addr == `ACSD_CTRL_OFS)
        |=> reg_rdata[`ACSD_LOCK_BIT] == $past(lock_flag))
        else $error("lock bit read does not match lock state");
    // the flag trails a disable by one cycle, so judge it by last cycle's inputs
    a_lock_needs_en: assert property (
        lock_flag |-> $past(ctrl_ff.aux_pll_enable) && $past(pll_lock_in))
        else $error("lock flag set without enabled locked pll");

endmodule : acsd_top

// File: hdl/acsd_cfg.svh
// acsd_cfg.svh: offsets, field positions and reset values of the aux clock block
// assumes: included by bare name from the modules and the testbench
`ifndef ACSD_CFG_SVH
`define ACSD_CFG_SVH

// ---------------------------------------------------------------------------
// register bus geometry
// ---------------------------------------------------------------------------
`define ACSD_ADDR_W          8
`define ACSD_DATA_W          16

// ---------------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------------
`define ACSD_CTRL_OFS        8'h00
`define ACSD_STAT_OFS        8'h04
`define ACSD_MASK_OFS        8'h08

// ---------------------------------------------------------------------------
// control register fields and values
// ---------------------------------------------------------------------------
`define ACSD_CTRL_RESET      16'h2700
`define ACSD_CTRL_WMASK      16'hA7C0
`define ACSD_LOCK_BIT        14

// ---------------------------------------------------------------------------
// event bits of status and mask
// ---------------------------------------------------------------------------
`define ACSD_EV_W            2
`define ACSD_EV_LOCK_GAIN    0
`define ACSD_EV_LOCK_LOSS    1
`define ACSD_EV_RESET        2'h0

// ---------------------------------------------------------------------------
// output divider
// ---------------------------------------------------------------------------
`define ACSD_DIV_CNT_W       7
`define ACSD_RATIO_BYPASS    3'h7

`endif

// File: hdl/acsd_pkg.sv
// acsd_pkg.sv: types shared by the aux clock source and divider block
// assumes: acsd_cfg.svh sits on the include path
package acsd_pkg;

    // -----------------------------------------------------------------------
    // control register layout
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic       aux_pll_enable;               // run the pll
        logic       aux_pll_lock_flag;            // read-only lock status
        logic       aux_divider_source_select;    // 1: vco, 0: primary osc
        logic [1:0] rsvd_hi;                      // reads zero
        logic [2:0] aux_output_divide_ratio;      // power-of-two code
        logic       aux_reference_select;         // 1: primary osc
        logic       internal_rc_reference_select; // 1: rc osc feeds pll
        logic [5:0] rsvd_lo;                      // reads zero
    } acsd_ctrl_s;

    // -----------------------------------------------------------------------
    // pll reference source code driven to the analog mux
    // -----------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACSD_REF_RC  = 2'b00,
        ACSD_REF_PRI = 2'b01,
        ACSD_REF_ALT = 2'b10
    } acsd_ref_e;

    // -----------------------------------------------------------------------
    // pll lock tracking states
    // -----------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACSD_PLL_OFF    = 2'b00,
        ACSD_PLL_WAIT   = 2'b01,
        ACSD_PLL_LOCKED = 2'b10
    } acsd_pll_e;

endpackage : acsd_pkg

// File: hdl/acsd_clk_div.sv
// acsd_clk_div.sv: power-of-two divider of a source tick stream
// assumes: src_tick is a one-cycle pulse synchronous to core_clk
`timescale 1ns/10ps
`include "acsd_cfg.svh"
module acsd_clk_div import acsd_pkg::*; #(
    parameter int CNT_W = `ACSD_DIV_CNT_W
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // source and ratio
    input  wire logic       src_tick,
    input  wire logic [2:0] ratio_code,
    // divided output
    output      logic       div_tick
);

    // -----------------------------------------------------------------------
    // state
    // -----------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_ff;       // source ticks seen in this period
    logic [CNT_W-1:0] nxt_cnt;
    logic             div_tick_ff;  // one pulse per period
    logic             nxt_div_tick;
    logic [CNT_W-1:0] terminal;     // last count of the period

    // code 7 gives terminal 0 (divide by 1), each step down doubles it
    assign terminal = {CNT_W{1'b1}} >> (3'h7 - (3'h7 - ratio_code)) ;

    // -----------------------------------------------------------------------
    // next count; >= lets a ratio cut short mid-period recover at once
    // -----------------------------------------------------------------------
    always_comb begin
        nxt_cnt      = cnt_ff;
        nxt_div_tick = 1'b0;
        if (src_tick) begin
            if (cnt_ff >= terminal) begin
                nxt_cnt      = '0;
                nxt_div_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // -----------------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_ff      <= '0;
            div_tick_ff <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            div_tick_ff <= nxt_div_tick;
        end
    end

    assign div_tick = div_tick_ff;

endmodule : acsd_clk_div

// File: sim/aux_clock_source_divider_tb.sv
// aux_clock_source_divider_tb.sv: self-checking bench of the aux clock block
// assumes: acsd_pkg and acsd_cfg.svh compiled first; ticks driven as pulses
`timescale 1ns/10ps
`include "acsd_cfg.svh"
module aux_clock_source_divider_tb import acsd_pkg::*;;
    // -----------------------------------------------------------------------
    // stimulus and observation
    // -----------------------------------------------------------------------
    logic        core_clk  = 1'b0;     // 100 MHz system clock
    logic        rst       = 1'b1;     // sync reset, high
    logic [7:0]  reg_addr  = 8'h00;    // register address
    logic [15:0] reg_wdata = 16'h0000; // write data
    logic        reg_wr    = 1'b0;     // write strobe
    logic        reg_rd    = 1'b0;     // read strobe
    logic [15:0] reg_rdata;            // read data
    logic [3:0]  ticks     = 4'h0;     // rc, primary, alt, vco pulses
    logic        lock_in   = 1'b0;     // analog lock level
    logic        pll_enable;           // pll run output
    acsd_ref_e   pll_ref_sel;          // reference code
    logic        pll_ref_tick;         // chosen reference tick
    logic        aux_clk_tick;         // divided output
    logic        irq;                  // interrupt level
    int          num_errors = 0;       // mismatches seen
    int          compares   = 0;       // comparisons made
    int          n_div      = 0;       // divided pulses counted
    logic [15:0] d;                    // last read value

    // -----------------------------------------------------------------------
    // clock, divided-pulse counter, device
    // -----------------------------------------------------------------------
    always #5 core_clk = ~core_clk;
    // counts pulses so ratios can be judged over many source ticks
    always @(posedge core_clk) begin
        if (aux_clk_tick === 1'b1) begin
            n_div <= n_div + 1;
        end
    end
    acsd_top u_acsd_top (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rc_osc_tick(ticks[0]), .primary_osc_tick(ticks[1]), .alt_ref_tick(ticks[2]),
        .pll_vco_tick(ticks[3]), .pll_lock_in(lock_in), .pll_enable(pll_enable),
        .pll_ref_sel(pll_ref_sel), .pll_ref_tick(pll_ref_tick),
        .aux_clk_tick(aux_clk_tick), .irq(irq)
    );

    // -----------------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // full 16 cycle reset, also used mid-run to restart divider phase
    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // one-cycle pulse on one source, sampled after the next edge
    task automatic pulse(input int idx);
        @(posedge core_clk);
        ticks[idx] <= 1'b1;
        @(posedge core_clk);
        ticks[idx] <= 1'b0;
        #1;
    endtask : pulse

    // -----------------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------------
    task automatic t_reset_and_access();
        rd(8'h00); check(d, 16'h2700);
        check(pll_enable, 16'h0000);
        rd(8'h0C); check(d, 16'h0000);
        wr(8'h0C, 16'hFFFF);
        wr(8'h00, 16'hFFFF);                // lock bit written high, not locked
        rd(8'h00); check(d, 16'hA7C0);
        check(pll_enable, 16'h0001);
        wr(8'h00, 16'h0000);
        rd(8'h00); check(d, 16'h0000);
        @(posedge core_clk);
        #1 check(pll_enable, 16'h0000);
    endtask : t_reset_and_access

    // rc select overrides the reference select; only the chosen tick passes
    task automatic t_ref_select();
        logic [1:0]  sel [4] = '{2'b10, 2'b11, 2'b01, 2'b00}; // rc, ref bits
        int          src [4] = '{0, 0, 1, 2};
        int          bad [4] = '{1, 1, 2, 1};
        acsd_ref_e   code[4] = '{ACSD_REF_RC, ACSD_REF_RC, ACSD_REF_PRI, ACSD_REF_ALT};
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 16'h8000 | {8'h00, sel[i][0], sel[i][1], 6'h00});
            repeat (2) @(posedge core_clk);
            #1 check(pll_ref_sel, code[i]);
            pulse(src[i]); check(pll_ref_tick, 16'h0001);
            pulse(bad[i]); check(pll_ref_tick, 16'h0000);
        end
        wr(8'h00, 16'h0080);                // pll off: reference gated
        repeat (2) @(posedge core_clk);
        pulse(1); check(pll_ref_tick, 16'h0000);
    endtask : t_ref_select

    // every divide code, counted over two output periods from a clean phase
    task automatic t_divider();
        int base;
        for (int c = 7; c >= 0; c--) begin
            do_reset();
            wr(8'h00, 16'hA000 | 16'(c << 8));
            base = n_div;
            for (int k = 0; k < 2 * (1 << (7 - c)) - 1; k++) begin
                pulse(3);
            end
            // a pulse out of the last tick is only counted at the next edge
            @(posedge core_clk);
            #1 check(16'(n_div - base), 16'h0001);
            pulse(3);
            repeat (2) @(posedge core_clk);
            check(16'(n_div - base), 16'h0002);
        end
        do_reset();
        wr(8'h00, 16'h8600);                // divider source: primary osc
        base = n_div;
        repeat (4) pulse(3);
        check(16'(n_div - base), 16'h0000);
        repeat (4) pulse(1);
        repeat (2) @(posedge core_clk);
        check(16'(n_div - base), 16'h0002);
    endtask : t_divider

    // lock flag, sticky events, mask and clear
    task automatic t_lock_irq();
        do_reset();
        wr(8'h08, 16'h0003);
        wr(8'h00, 16'h8000);
        lock_in <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(8'h00); check(d, 16'hC000);
        check(irq, 16'h0001);
        rd(8'h04); check(d, 16'h0001);
        wr(8'h04, 16'h0001);
        rd(8'h04); check(d, 16'h0000);
        check(irq, 16'h0000);
        wr(8'h00, 16'h8000);                // zero written to the lock bit
        rd(8'h00); check(d, 16'hC000);
        lock_in <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(8'h00); check(d, 16'h8000);
        rd(8'h04); check(d, 16'h0002);
        check(irq, 16'h0001);
        wr(8'h08, 16'h0000);
        repeat (2) @(posedge core_clk);
        #1 check(irq, 16'h0000);
        wr(8'h04, 16'h0003);
        wr(8'h00, 16'h0000);
        lock_in <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(8'h00); check(d, 16'h0000);
        rd(8'h04); check(d, 16'h0000);
    endtask : t_lock_irq

    // -----------------------------------------------------------------------
    // verdict, main sequence, watchdog
    // -----------------------------------------------------------------------
    task automatic close_out();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        do_reset();
        t_reset_and_access();
        t_ref_select();
        t_divider();
        t_lock_irq();
        close_out();
    end
    // main sequence takes about 1400 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        close_out();
    end
endmodule : aux_clock_source_divider_tb
